/* hdl/sdv_pkg.sv */
// Constants shared by the stepper driver serial slave: addresses, bit positions,
// reset values and the status parity function.
// Assumes every user writes sdv_pkg::name; nothing is imported.
package sdv_pkg;

  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned WRITE_BITS = 16;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned STAT_W     = 7;
  localparam int unsigned N_STAT     = 4;
  localparam int unsigned N_CTRL     = 3;

  // Command byte layout
  localparam int unsigned CMD_TYPE_POS = 7;

  // Register map
  localparam logic [4:0] ADDR_CTRL0 = 5'h01;
  localparam logic [4:0] ADDR_CTRL1 = 5'h02;
  localparam logic [4:0] ADDR_CTRL2 = 5'h03;
  localparam logic [4:0] ADDR_STAT0 = 5'h04;
  localparam logic [4:0] ADDR_STAT3 = 5'h07;

  // Control register 2 fields
  localparam int unsigned MOTOR_EN_POS = 7;
  localparam int unsigned SLEEP_POS = 6;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] STAT_RESET = 7'h00;
  localparam logic [4:0] CNT_MAX    = 5'h1F;

  // Top bit is one when the seven data bits hold an odd count of ones
  function automatic logic [7:0] sdv_with_parity(input logic [6:0] data);
    sdv_with_parity = {^data, data};
  endfunction : sdv_with_parity

  function automatic logic sdv_is_ctrl(input logic [4:0] addr);
    sdv_is_ctrl = (addr >= ADDR_CTRL0) && (addr <= ADDR_CTRL2);
  endfunction : sdv_is_ctrl

  function automatic logic sdv_is_stat(input logic [4:0] addr);
    sdv_is_stat = (addr >= ADDR_STAT0) && (addr <= ADDR_STAT3);
  endfunction : sdv_is_stat

endpackage : sdv_pkg

/* hdl/sdv_spi_slave.sv */
// Serial slave of a stepper motor driver: mode-0 shift logic, control
// registers, clear-on-read status registers, hard reset and sleep outputs.
// Assumes serial pins and hard reset come from outside the sys_clk domain
// and that the serial clock is much slower than sys_clk (bench: 160 ns).
//
// Behaviour
// - Hard reset pin high resets the register, shift and status logic; low lets the device run.
// - Hard reset clears every register; charge pump enable stays on.
// - Sleep bit tri-states bridge, disables analog, keeps register contents.
// - Sleep stops oscillator except during transfers; serial access and reset still work.
// - Device is only a slave and never starts a transfer.
// - Select is active low; data output released when not selected.
// - Mode zero: clock idles low, output on falling, sample on rising.
// - Most significant bit first; first byte command and address, then data.
// - Five-bit address; command type bit zero reads, one writes.
// - Falling edge after each eighth bit loads addressed register for shifting.
// - Bits received while read data shifts out form the next command.
// - Status words carry seven data bits and an even-parity top bit.
// - Control registers read the same way, without a parity bit.
// - Reading a status register clears its latched status.
// - Status and fault flag update only while select is high.
// - Written data commits to the control register on select rising.
// - A write packet of other than sixteen bits is discarded whole.
// - Writes to read-only registers change nothing.
// - Each byte shifts out the last received address; first after reset shifts out zero.
// - Control registers are read/write and reset to zero.
`timescale 1ns/1ns
module sdv_spi_slave (
  // Clock and reset
  input  wire logic                                       sys_clk,
  input  wire logic                                       rst,
  // Hard reset pin
  input  wire logic                                       hard_reset_input,
  // Serial pins
  input  wire logic                                       serial_clk,
  input  wire logic                                       slave_select_n,
  input  wire logic                                       serial_in,
  output logic                                            serial_out,
  output logic                                            serial_out_oe_n,
  // Diagnostic events, one-cycle pulses
  input  wire logic [sdv_pkg::N_STAT*sdv_pkg::STAT_W-1:0] status_events,
  // Error pin, open drain
  output logic                                            fault_flag_n,
  output logic                                            fault_flag_oe_n,
  // Control register contents
  output logic      [7:0]                                 ctrl0,
  output logic      [7:0]                                 ctrl1,
  output logic      [7:0]                                 ctrl2,
  // Power management
  output logic                                            bridge_hiz,
  output logic                                            analog_enable,
  output logic                                            osc_run,
  output logic                                            charge_pump_enable
);

  localparam int unsigned SW = sdv_pkg::N_STAT * sdv_pkg::STAT_W;

  logic [3:0]    pins_s;
  logic          hard_rst_s;
  logic          sclk_s;
  logic          sel_n_s;
  logic          sdi_s;
  logic          logic_rst;
  logic          sclk_prev_q;
  logic          sel_n_prev_q;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          sel_rise;
  logic          selected;
  logic [4:0]    bit_cnt_q;
  logic [7:0]    rx_q;
  logic [7:0]    rx_d;
  logic          byte_done;
  logic          data_phase_q;
  logic [4:0]    addr_q;
  logic          rd_cmd_q;
  logic          first_wr_q;
  logic [4:0]    first_addr_q;
  logic [7:0]    wdata_q;
  logic          load_due_q;
  logic [7:0]    tx_q;
  logic [7:0]    ctrl_q [sdv_pkg::N_CTRL];
  logic [SW-1:0] stat;
  logic          fault_n;
  logic [3:0]    clear_req;
  logic          commit;

  // Pins cross into sys_clk through two flops each; select travels inverted
  // so that the flops' cleared state reads as deselected after reset
  // clock and select only come in: the slave never starts a frame
  sdv_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (sys_clk),
    .rst      (rst),
    .async_in ({hard_reset_input, serial_clk, ~slave_select_n, serial_in}),
    .sync_out (pins_s)
  );

  assign hard_rst_s = pins_s[3];
  assign sclk_s     = pins_s[2];
  assign sel_n_s    = ~pins_s[1];
  assign sdi_s      = pins_s[0];

  assign logic_rst = rst | hard_rst_s;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_prev_q  <= 1'b0;
      sel_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q  <= sclk_s;
      sel_n_prev_q <= sel_n_s;
    end
  end

  assign selected  = ~sel_n_s;
  assign sclk_rise = selected & sclk_s & ~sclk_prev_q;
  assign sclk_fall = selected & ~sclk_s & sclk_prev_q;
  assign sel_rise  = sel_n_s & ~sel_n_prev_q;
  assign rx_d      = {rx_q[6:0], sdi_s};
  assign byte_done = sclk_rise && (bit_cnt_q[2:0] == 3'h7);

  // count bits of the packet, saturating
  always_ff @(posedge sys_clk) begin
    if (logic_rst || sel_n_s) begin
      bit_cnt_q <= '0;
    end else if (sclk_rise && bit_cnt_q != sdv_pkg::CNT_MAX) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      rx_q <= '0;
    end else if (sclk_rise) begin
      rx_q <= rx_d;
    end
  end

  // a byte is a command unless it carries write data
  always_ff @(posedge sys_clk) begin
    if (logic_rst || sel_n_s) begin
      data_phase_q <= 1'b0;
    end else if (byte_done) begin
      data_phase_q <= data_phase_q ? 1'b0 : rx_d[sdv_pkg::CMD_TYPE_POS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      addr_q   <= '0;
      rd_cmd_q <= 1'b0;
    end else if (byte_done && !data_phase_q) begin
      addr_q   <= rx_d[sdv_pkg::ADDR_W-1:0];
      rd_cmd_q <= ~rx_d[sdv_pkg::CMD_TYPE_POS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      first_wr_q   <= 1'b0;
      first_addr_q <= '0;
      wdata_q      <= '0;
    end else if (byte_done && bit_cnt_q == 5'h07) begin
      first_wr_q   <= rx_d[sdv_pkg::CMD_TYPE_POS];
      first_addr_q <= rx_d[sdv_pkg::ADDR_W-1:0];
    end else if (byte_done && bit_cnt_q == 5'h0F) begin
      wdata_q <= rx_d;
    end
  end

  // load arms at eighth rising, fires at next falling
  always_ff @(posedge sys_clk) begin
    if (logic_rst || sel_n_s) begin
      load_due_q <= 1'b0;
    end else if (byte_done) begin
      load_due_q <= 1'b1;
    end else if (sclk_fall) begin
      load_due_q <= 1'b0;
    end
  end

  // shift out the last received address
  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      tx_q <= '0;
    end else if (sclk_fall && load_due_q) begin
      if (sdv_pkg::sdv_is_stat(addr_q)) begin
        tx_q <= sdv_pkg::sdv_with_parity(
                  stat[(addr_q - sdv_pkg::ADDR_STAT0) * sdv_pkg::STAT_W +: sdv_pkg::STAT_W]);
      end else if (sdv_pkg::sdv_is_ctrl(addr_q)) begin
        tx_q <= ctrl_q[2'(addr_q - sdv_pkg::ADDR_CTRL0)];
      end else begin
        tx_q <= '0;
      end
    end else if (sclk_fall) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // clear the status word that is loaded
  // a write command aimed at a status word leaves it alone
  always_comb begin
    clear_req = '0;
    if (sclk_fall && load_due_q && rd_cmd_q && sdv_pkg::sdv_is_stat(addr_q)) begin
      clear_req[2'(addr_q - sdv_pkg::ADDR_STAT0)] = 1'b1;
    end
  end

  sdv_status_bank u_status (
    .clk       (sys_clk),
    .rst       (logic_rst),
    .upd_en    (sel_n_s),
    .clear_req (clear_req),
    .events    (status_events),
    .stat_q    (stat),
    .fault_n_q (fault_n)
  );

  // commit on select rising; exactly sixteen bits; control only
  assign commit = sel_rise && bit_cnt_q == 5'(sdv_pkg::WRITE_BITS) && first_wr_q
                  && sdv_pkg::sdv_is_ctrl(first_addr_q);

  generate
    for (genvar g = 0; g < sdv_pkg::N_CTRL; g++) begin : g_ctrl
      always_ff @(posedge sys_clk) begin
        if (logic_rst) begin
          ctrl_q[g] <= sdv_pkg::CTRL_RESET;
        end else if (commit && first_addr_q == 5'(g + 1)) begin
          ctrl_q[g] <= wdata_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out      <= 1'b0;
      serial_out_oe_n <= ~(selected & ~tx_q[7]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      fault_flag_n    <= 1'b1;
      fault_flag_oe_n <= 1'b1;
    end else begin
      fault_flag_n    <= 1'b0;
      fault_flag_oe_n <= fault_n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      ctrl0 <= sdv_pkg::CTRL_RESET;
      ctrl1 <= sdv_pkg::CTRL_RESET;
      ctrl2 <= sdv_pkg::CTRL_RESET;
    end else begin
      ctrl0 <= ctrl_q[0];
      ctrl1 <= ctrl_q[1];
      ctrl2 <= ctrl_q[2];
    end
  end

  // sleep tri-states bridge and analog; clocks run while selected
  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      bridge_hiz    <= 1'b1;
      analog_enable <= 1'b1;
      osc_run       <= 1'b1;
    end else begin
      bridge_hiz    <= ctrl_q[2][sdv_pkg::SLEEP_POS] | ~ctrl_q[2][sdv_pkg::MOTOR_EN_POS];
      analog_enable <= ~ctrl_q[2][sdv_pkg::SLEEP_POS];
      osc_run       <= ~ctrl_q[2][sdv_pkg::SLEEP_POS] | selected;
    end
  end

  // charge pump stays on through hard reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      charge_pump_enable <= 1'b1;
    end else begin
      charge_pump_enable <= 1'b1;
    end
  end

  // Checks
  ctrl_reset_a: assert property (@(posedge sys_clk)
    logic_rst |=> ctrl_q[0] == 8'h00 && ctrl_q[1] == 8'h00 && ctrl_q[2] == 8'h00)
    else $error("control register not zero after reset");

  pump_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    hard_rst_s |=> charge_pump_enable)
    else $error("charge pump dropped during hard reset");

  sdo_release_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    sel_n_s |=> serial_out_oe_n)
    else $error("data output driven while deselected");

  write_commit_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    commit |=> ctrl_q[2'(first_addr_q - 5'h01)] == $past(wdata_q))
    else $error("write data not committed");

  short_write_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    sel_rise && bit_cnt_q != 5'h10
    |=> ctrl_q[0] == $past(ctrl_q[0]) && ctrl_q[1] == $past(ctrl_q[1])
        && ctrl_q[2] == $past(ctrl_q[2]))
    else $error("bad-length write changed a control register");

  no_commit_low_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    selected |=> ctrl_q[1] == $past(ctrl_q[1]))
    else $error("control register changed while selected");

  parity_load_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    sclk_fall && load_due_q && sdv_pkg::sdv_is_stat(addr_q) |=> ^tx_q == 1'b0)
    else $error("status byte parity wrong");

  ctrl_load_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    sclk_fall && load_due_q && addr_q == 5'h03 |=> tx_q == $past(ctrl_q[2]))
    else $error("control read returned wrong data");

  shift_msb_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    sclk_fall && !load_due_q |=> tx_q == {$past(tx_q[6:0]), 1'b0})
    else $error("output shift wrong");

  sleep_out_a: assert property (@(posedge sys_clk) disable iff (logic_rst)
    ctrl_q[2][6] ##1 ctrl_q[2][6] |-> bridge_hiz && !analog_enable)
    else $error("sleep did not quiet the bridge");

  read_cover: cover property (@(posedge sys_clk) sclk_fall && load_due_q
                              && sdv_pkg::sdv_is_stat(addr_q));
  write_cover: cover property (@(posedge sys_clk) commit);
  sleep_cover: cover property (@(posedge sys_clk) ctrl_q[2][6] && selected);

endmodule : sdv_spi_slave

/* hdl/sdv_status_bank.sv */
// Sticky status words with clear-on-read and the active-low fault flag.
// Assumes upd_en is high only while the slave select pin is high.
`timescale 1ns/1ns
module sdv_status_bank (
  // Clock and reset
  input  wire logic                                       clk,
  input  wire logic                                       rst,
  // Control
  input  wire logic                                       upd_en,
  input  wire logic [sdv_pkg::N_STAT-1:0]                 clear_req,
  input  wire logic [sdv_pkg::N_STAT*sdv_pkg::STAT_W-1:0] events,
  // State
  output logic      [sdv_pkg::N_STAT*sdv_pkg::STAT_W-1:0] stat_q,
  output logic                                            fault_n_q
);

  localparam int unsigned SW = sdv_pkg::N_STAT * sdv_pkg::STAT_W;

  logic [SW-1:0] ev_hold_q;
  logic [SW-1:0] clear_mask_q;
  logic [SW-1:0] stat_d;

  // Events seen while selected wait here for the next update window
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_hold_q <= '0;
    end else if (upd_en) begin
      ev_hold_q <= '0;
    end else begin
      ev_hold_q <= ev_hold_q | events;
    end
  end

  // Read clears wait for the update window as well
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_mask_q <= '0;
    end else if (upd_en) begin
      clear_mask_q <= '0;
    end else begin
      for (int i = 0; i < sdv_pkg::N_STAT; i++) begin
        if (clear_req[i]) begin
          clear_mask_q[i*sdv_pkg::STAT_W +: sdv_pkg::STAT_W] <= '1;
        end
      end
    end
  end

  assign stat_d = (stat_q & ~clear_mask_q) | ev_hold_q | events;

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q    <= {sdv_pkg::N_STAT{sdv_pkg::STAT_RESET}};
      fault_n_q <= 1'b1;
    end else if (upd_en) begin
      stat_q    <= stat_d;
      fault_n_q <= ~(|stat_d);
    end
  end

  stat_frozen_a: assert property (@(posedge clk) disable iff (rst)
    !upd_en |=> stat_q == $past(stat_q))
    else $error("status changed while selected");

  fault_flag_a: assert property (@(posedge clk) disable iff (rst)
    upd_en |=> fault_n_q == ~(|stat_q))
    else $error("fault flag disagrees with status");

endmodule : sdv_status_bank

/* hdl/sdv_sync.sv */
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level relative to clk; no bus coherency.
`timescale 1ns/1ns
module sdv_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sdv_sync

/* testbench/sdv_master_model.sv */
// Mode-0 serial master that drives the slave's select, clock and data pins.
// Assumes a pull-up on the data-out line and a 125 MHz sys_clk.
`timescale 1ns/1ns
module sdv_master_model (
  // Clock
  input  wire logic       sys_clk,
  // Slave data out
  input  wire logic       serial_out,
  input  wire logic       serial_out_oe_n,
  // Serial pins
  output logic            serial_clk,
  output logic            slave_select_n,
  output logic            serial_in,
  // Received bytes
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  logic       idle_q = 1'b1;
  logic [7:0] sh;
  wire        do_line = serial_out_oe_n ? 1'b1 : serial_out;

  initial begin
    serial_clk     = 1'b0;
    slave_select_n = 1'b1;
    serial_in      = 1'b0;
    rx_valid       = 1'b0;
    rx_byte        = 8'h00;
  end

  // Undriven data line wanders between frames
  always @(posedge sys_clk) begin
    if (idle_q) serial_in <= ~serial_in;
    if (rx_valid) rx_valid <= 1'b0;
  end

  task automatic half();
    repeat (10) @(posedge sys_clk);
  endtask : half

  // mode 0, MSB first, select held high between frames
  task automatic frame(input int n_bits, input logic [31:0] data);
    idle_q <= 1'b0;
    @(posedge sys_clk);
    slave_select_n <= 1'b0;
    for (int i = n_bits - 1; i >= 0; i--) begin
      serial_in <= data[i];
      half();
      serial_clk <= 1'b1;
      sh = {sh[6:0], do_line};
      if (i % 8 == (n_bits % 8)) begin
        rx_byte  <= sh;
        rx_valid <= 1'b1;
      end
      half();
      serial_clk <= 1'b0;
    end
    half();
    slave_select_n <= 1'b1;
    idle_q         <= 1'b1;
    repeat (20) @(posedge sys_clk);
  endtask : frame
endmodule : sdv_master_model

/* testbench/sdv_spi_slave_test.sv */
// Self-checking bench of the serial slave: writes, chained reads, bad lengths,
// status parity and clear, sleep and hard reset.
// Assumes sdv_pkg and the master model are compiled first.
`timescale 1ns/1ns
module sdv_spi_slave_test;
  logic        sys_clk, rst, hard_reset_input;
  logic [27:0] status_events;
  logic        serial_clk, slave_select_n, serial_in, serial_out, serial_out_oe_n;
  logic        fault_flag_n, fault_flag_oe_n, bridge_hiz, analog_enable;
  logic        osc_run, charge_pump_enable, rx_valid;
  logic [7:0]  ctrl0, ctrl1, ctrl2, rx_byte, v;
  logic [6:0]  sv;
  logic [8:0]  e;
  logic [8:0]  exp_q[$];
  logic [7:0]  ctrl_m[1:3];
  int          miscompares = 0;
  int          checks_done = 0;
  int          seed = 32'h9b76;

  sdv_spi_slave u_dut (.sys_clk(sys_clk), .rst(rst), .hard_reset_input(hard_reset_input),
    .serial_clk(serial_clk), .slave_select_n(slave_select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .status_events(status_events), .fault_flag_n(fault_flag_n),
    .fault_flag_oe_n(fault_flag_oe_n), .ctrl0(ctrl0), .ctrl1(ctrl1), .ctrl2(ctrl2),
    .bridge_hiz(bridge_hiz), .analog_enable(analog_enable), .osc_run(osc_run),
    .charge_pump_enable(charge_pump_enable));

  sdv_master_model u_master (.sys_clk(sys_clk), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .serial_clk(serial_clk),
    .slave_select_n(slave_select_n), .serial_in(serial_in), .rx_valid(rx_valid),
    .rx_byte(rx_byte));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checks_done++;
    if (act !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Byte 0 is left unchecked; byte 1 is the pointer's old content and is checked
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [7:0] old);
    exp_q.push_back(9'h000);
    exp_q.push_back({1'b1, old});
    u_master.frame(16, {16'h0000, 3'b100, a, d});
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    exp_q.push_back(9'h000);
    exp_q.push_back({1'b1, exp});
    u_master.frame(16, {16'h0000, 3'b000, a, 8'h00});
  endtask : rd

  // Received bytes against the oldest note
  always @(posedge sys_clk) begin
    if (rx_valid) begin
      if (exp_q.size() == 0) begin
        chk(rx_byte, 8'hxx);
      end else begin
        e = exp_q.pop_front();
        if (e[8]) chk(rx_byte, e[7:0]);
      end
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    $display("timeout t=%0t", $time);
    close_out();
  end

  initial begin
    rst              = 1'b1;
    hard_reset_input = 1'b0;
    status_events    = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({ctrl0 | ctrl1 | ctrl2}, 8'h00);
    chk({4'h0, serial_out, fault_flag_n, serial_out_oe_n, fault_flag_oe_n}, 8'h03);
    chk({6'h00, analog_enable, charge_pump_enable}, 8'h03);
    $display("test reset done");
    for (int a = 1; a <= 3; a++) begin
      v = 8'($random(seed));
      wr(5'(a), v, 8'h00);
      ctrl_m[a] = v;
    end
    chk(ctrl0, ctrl_m[1]);
    chk(ctrl1, ctrl_m[2]);
    chk(ctrl2, ctrl_m[3]);
    exp_q.push_back(9'h000);
    for (int a = 1; a <= 3; a++) exp_q.push_back({1'b1, ctrl_m[a]});
    u_master.frame(32, 32'h0102_0300);
    $display("test write and read chain done");
    // short, long and read-only writes change nothing
    exp_q.push_back(9'h000);
    u_master.frame(15, {8'h82, ~ctrl_m[2]} >> 1);
    exp_q.push_back(9'h000);
    exp_q.push_back({1'b1, ctrl_m[2]});
    u_master.frame(17, {8'h82, ~ctrl_m[2], 1'b0});
    wr(5'h05, 8'h7f, 8'h00);
    wr(5'h00, 8'h55, 8'h00);
    rd(5'h05, 8'h00);
    chk(ctrl1, ctrl_m[2]);
    chk(ctrl0, ctrl_m[1]);
    $display("test refused writes done");
    for (int i = 0; i < 4; i++) begin
      sv = 7'($random(seed)) | 7'h01;
      status_events <= 28'(sv) << (7 * i);
      @(posedge sys_clk);
      status_events <= '0;
      repeat (10) @(posedge sys_clk);
      chk({7'h00, fault_flag_oe_n}, 8'h00);
      wr(5'(4 + i), 8'h00, {^sv, sv});
      rd(5'(4 + i), {^sv, sv});
      rd(5'(4 + i), 8'h00);
      chk({7'h00, fault_flag_oe_n}, 8'h01);
    end
    $display("test status done");
    wr(5'h03, 8'h40, ctrl_m[3]);
    chk({5'h00, bridge_hiz, analog_enable, osc_run}, 8'h04);
    fork
      rd(5'h01, ctrl_m[1]);
      begin
        repeat (100) @(posedge sys_clk);
        chk({7'h00, osc_run}, 8'h01);
      end
    join
    chk(ctrl1, ctrl_m[2]);
    wr(5'h03, 8'h80, 8'h40);
    chk({5'h00, bridge_hiz, analog_enable, osc_run}, 8'h03);
    $display("test sleep done");
    hard_reset_input <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({7'h00, charge_pump_enable}, 8'h01);
    hard_reset_input <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({ctrl0 | ctrl1 | ctrl2}, 8'h00);
    rd(5'h03, 8'h00);
    $display("test hard reset done");
    chk(8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule : sdv_spi_slave_test
